// File: logic/rcmb_pkg.sv
// Purpose: constants and types of the reset source combiner
// Assumes: one clock, registers reached over avalon-mm with 32-bit data
// Notes:   cause vector bit 0 is power-on, bits 8..1 follow the source struct

package rcmb_pkg;

	// ----------------------------------------------------------------
	// cause vector layout
	// ----------------------------------------------------------------
	localparam int unsigned RCMB_CAUSE_W = 9;
	typedef logic [RCMB_CAUSE_W-1:0] rcmb_cause_type;

	localparam int unsigned RCMB_BIT_POR = 0;
	localparam int unsigned RCMB_BIT_BOR = 1;
	localparam int unsigned RCMB_BIT_SWR = 2;
	localparam int unsigned RCMB_BIT_WDT = 3;
	localparam int unsigned RCMB_BIT_PIN = 4;
	localparam int unsigned RCMB_BIT_CM = 5;
	localparam int unsigned RCMB_BIT_IOP = 6;
	localparam int unsigned RCMB_BIT_UWR = 7;
	localparam int unsigned RCMB_BIT_TRAP = 8;

	// non-power-on sources, msb first so {src, 1'b0} matches the bits above
	typedef struct packed {
		logic trap_conflict_reset;
		logic uninit_wreg_reset;
		logic illegal_opcode_reset;
		logic config_mismatch_reset;
		logic external_pin_reset;
		logic watchdog_timeout_reset;
		logic software_instruction_reset;
		logic brownout_reset_source;
	} rcmb_src_type;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam rcmb_cause_type RCMB_CAUSE_POR_VAL = 9'h003;
	localparam rcmb_cause_type RCMB_STAT_RST_VAL = 9'h003;
	localparam rcmb_cause_type RCMB_MASK_RST_VAL = 9'h000;
	localparam logic [31:0] RCMB_RDATA_RST_VAL = 32'h0000_0000;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam int unsigned RCMB_ADDR_W = 4;
	localparam logic [RCMB_ADDR_W-1:0] RCMB_OFS_CAUSE = 4'h0;
	localparam logic [RCMB_ADDR_W-1:0] RCMB_OFS_STAT = 4'h4;
	localparam logic [RCMB_ADDR_W-1:0] RCMB_OFS_MASK = 4'h8;
	localparam logic [RCMB_ADDR_W-1:0] RCMB_OFS_SCRATCH = 4'hc;

	typedef struct packed {
		logic read;
		logic write;
		logic [RCMB_ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} rcmb_avreq_type;

	// bus slave states, one-hot
	typedef enum logic [1:0] {
		RCMB_ST_IDLE = 2'b01,
		RCMB_ST_ACK = 2'b10
	} rcmb_state_type;

endpackage

// File: logic/rcmb_top.sv
// Purpose: merge the reset sources into the master system reset and keep
//          a software readable record of which source caused it
// Assumes: all source inputs are levels synchronous to clk_i; rst_n_i is
//          the power-on reset of the device
// Notes:   one wait state on every bus access; read of the event status
//          register clears the bits it returned
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.

`timescale 1ns/100ps

// What this block does
// - master system reset goes active whenever at least one source is active.
// - all nine reset sources, power-on included, feed master reset.
// - while master reset is active, only the mask register is held at its reset value.
// - unreset storage survives non-power-on resets, undefined after power-on.
// - each kind of reset sets its own flag in the reset cause register.
// - power-on clears all cause flags but sets brown-out and power-on, 1:0.
// - software may write any cause flag to one or zero, except that an active source keeps its flag set.
// - a software write to a cause flag never drives master reset.
module rcmb_top
	import rcmb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire rcmb_src_type rst_src_i,
	input wire rcmb_avreq_type av_req_i,
	output logic [31:0] av_readdata_o,
	output logic av_waitrequest_o,
	output logic master_system_reset_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] be_to_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	function automatic rcmb_cause_type merge_field(
		input rcmb_cause_type old_v,
		input logic [31:0] wdata,
		input logic [3:0] be
	);
		logic [31:0] m;
		m = be_to_mask(be);
		return (old_v & ~m[RCMB_CAUSE_W-1:0]) |
			(wdata[RCMB_CAUSE_W-1:0] & m[RCMB_CAUSE_W-1:0]);
	endfunction

	function automatic logic [31:0] pad_cause(input rcmb_cause_type v);
		return {{(32-RCMB_CAUSE_W){1'b0}}, v};
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	rcmb_state_type state_q;
	rcmb_cause_type src_vec;
	rcmb_cause_type src_prev_q;
	rcmb_cause_type src_rise;
	rcmb_cause_type cause_q;
	rcmb_cause_type cause_d;
	rcmb_cause_type stat_q;
	rcmb_cause_type stat_clr;
	rcmb_cause_type mask_q;
	logic [31:0] scratch_q;
	logic [31:0] rdata_q;
	logic wait_q;
	logic master_q;
	logic irq_q;
	logic req_seen;
	logic do_wr;
	logic do_rd;

	// power-on is the async reset itself, so it never shows in the vector
	assign src_vec = {rst_src_i, 1'b0};
	assign src_rise = src_vec & ~src_prev_q;

	assign req_seen = (state_q == RCMB_ST_IDLE) &&
		(av_req_i.read || av_req_i.write);
	assign do_wr = (state_q == RCMB_ST_ACK) && av_req_i.write;
	assign do_rd = (state_q == RCMB_ST_ACK) && av_req_i.read;

	// ----------------------------------------------------------------
	// master system reset
	// ----------------------------------------------------------------
	// any active source drives master reset
	// only source inputs reach this flop
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			master_q <= 1'b1;
		end else begin
			master_q <= |src_vec;
		end
	end

	// ----------------------------------------------------------------
	// reset cause register
	// ----------------------------------------------------------------
	always_comb begin
		cause_d = cause_q;
		if (do_wr && av_req_i.address == RCMB_OFS_CAUSE) begin
			cause_d = merge_field(cause_q, av_req_i.writedata,
				av_req_i.byteenable);
		end
		// active source sets its flag, winning over a clearing write
		cause_d = cause_d | src_vec;
	end

	// power-on leaves only brown-out and power-on set
	// master reset is not a term here, flags survive it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cause_q <= RCMB_CAUSE_POR_VAL;
		end else begin
			cause_q <= cause_d;
		end
	end

	// ----------------------------------------------------------------
	// event status and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_prev_q <= RCMB_MASK_RST_VAL;
		end else begin
			src_prev_q <= src_vec;
		end
	end

	// clear only what the read returned, so a bit set during the wait
	// state is not lost
	assign stat_clr = (do_rd && av_req_i.address == RCMB_OFS_STAT) ?
		rdata_q[RCMB_CAUSE_W-1:0] : RCMB_MASK_RST_VAL;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_q <= RCMB_STAT_RST_VAL;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | src_rise;
		end
	end

	// mask forced to its reset value under master reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_q <= RCMB_MASK_RST_VAL;
		end else if (master_q) begin
			mask_q <= RCMB_MASK_RST_VAL;
		end else if (do_wr && av_req_i.address == RCMB_OFS_MASK) begin
			mask_q <= merge_field(mask_q, av_req_i.writedata,
				av_req_i.byteenable);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	// ----------------------------------------------------------------
	// scratch word without reset
	// ----------------------------------------------------------------
	// no reset term, content kept through master reset
	always_ff @(posedge clk_i) begin
		if (do_wr && av_req_i.address == RCMB_OFS_SCRATCH) begin
			scratch_q <= (scratch_q & ~be_to_mask(av_req_i.byteenable)) |
				(av_req_i.writedata & be_to_mask(av_req_i.byteenable));
		end
	end

	// ----------------------------------------------------------------
	// avalon-mm slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= RCMB_ST_IDLE;
		end else begin
			unique case (state_q)
				RCMB_ST_IDLE: begin
					if (req_seen) begin
						state_q <= RCMB_ST_ACK;
					end
				end
				RCMB_ST_ACK: begin
					state_q <= RCMB_ST_IDLE;
				end
				default: begin
					state_q <= RCMB_ST_IDLE;
				end
			endcase
		end
	end

	// waitrequest drops for the single ack cycle only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !req_seen;
		end
	end

	// read data captured on entry to ack; unmapped addresses read zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= RCMB_RDATA_RST_VAL;
		end else if (req_seen && av_req_i.read) begin
			unique case (av_req_i.address)
				RCMB_OFS_CAUSE: rdata_q <= pad_cause(cause_q);
				RCMB_OFS_STAT: rdata_q <= pad_cause(stat_q);
				RCMB_OFS_MASK: rdata_q <= pad_cause(mask_q);
				RCMB_OFS_SCRATCH: rdata_q <= scratch_q;
				default: rdata_q <= RCMB_RDATA_RST_VAL;
			endcase
		end
	end

	assign av_readdata_o = rdata_q;
	assign av_waitrequest_o = wait_q;
	assign master_system_reset_o = master_q;
	assign irq_o = irq_q;

endmodule // rcmb_top

// File: testbench/rcmb_src_model.sv
// Purpose: reset cause detector model feeding the combiner's sources
// Assumes: fire_i pulses for one cycle, synchronous to clk_i
// Notes:   hold sets how long a fired source stays active
`timescale 1ns/100ps
module rcmb_src_model
	import rcmb_pkg::*;
#(
	parameter int HOLD = 3
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire rcmb_src_type fire_i,
	output rcmb_src_type src_o
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_o <= '0;
			cnt_q <= 4'h0;
		end else if (|fire_i) begin
			src_o <= fire_i;
			cnt_q <= 4'(HOLD);
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else begin
			src_o <= '0;
		end
	end
endmodule // rcmb_src_model

// File: testbench/rcmb_assertions.sv
// Purpose: port checks of the reset source combiner
// Assumes: one clock, one wait state per bus access
// Notes:   bound to rcmb_top at the foot of this file
`timescale 1ns/100ps
module rcmb_assertions
	import rcmb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire rcmb_src_type rst_src_i,
	input wire rcmb_avreq_type av_req_i,
	input wire logic [31:0] av_readdata_o,
	input wire logic av_waitrequest_o,
	input wire logic master_system_reset_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_ack;
		!av_waitrequest_o ##1 av_waitrequest_o;
	endsequence
	sequence s_rd_done;
		!av_waitrequest_o && av_req_i.read;
	endsequence
	a_src_sets_rst: assert property (|rst_src_i |=> master_system_reset_o)
		else $error("master reset missing after a source");
	a_rst_needs_src: assert property ($rose(master_system_reset_o)
		|-> $past(|rst_src_i)) else $error("master reset without source");
	a_quiet_no_rst: assert property (!(|rst_src_i) |=>
		!master_system_reset_o) else $error("master reset with no source");
	a_irq_off_rst: assert property (master_system_reset_o [*2] |=> !irq_o)
		else $error("interrupt while master reset held");
	a_cause_has_src: assert property (s_rd_done
		and av_req_i.address == RCMB_OFS_CAUSE |->
		(av_readdata_o[8:1] & $past(rst_src_i, 2)) == $past(rst_src_i, 2))
		else $error("active source missing from cause read");
	a_upper_zero: assert property (s_rd_done
		and av_req_i.address != RCMB_OFS_SCRATCH |->
		av_readdata_o[31:9] == 23'h0) else $error("upper read bits set");
	a_bus_ack: assert property ((av_req_i.read || av_req_i.write)
		&& av_waitrequest_o |=> s_ack) else $error("bus answer not one wait");
	a_ack_needs_req: assert property ($fell(av_waitrequest_o) |->
		$past(av_req_i.read || av_req_i.write)) else $error("ack without request");
endmodule // rcmb_assertions
bind rcmb_top rcmb_assertions i_chk (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.rst_src_i(rst_src_i),
	.av_req_i(av_req_i),
	.av_readdata_o(av_readdata_o),
	.av_waitrequest_o(av_waitrequest_o),
	.master_system_reset_o(master_system_reset_o),
	.irq_o(irq_o)
);

// File: testbench/reset_source_combiner_tb.sv
// Purpose: self-checking bench of the reset source combiner
// Assumes: detector model holds each fired source for four cycles
// Notes:   scratch after power-on is undefined, so never compared then
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("MISMATCH %s exp %0h got %0h", n, e, g); \
	end \
end
module reset_source_combiner_tb
	import rcmb_pkg::*;
;
	logic clk_i, rst_n_i, mrst, irq, wr;
	logic [31:0] rd;
	rcmb_src_type fire, src;
	rcmb_avreq_type req;
	int err_count = 0, num_checks = 0, cyc = 0;
	rcmb_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rst_src_i(src),
		.av_req_i(req), .av_readdata_o(rd), .av_waitrequest_o(wr),
		.master_system_reset_o(mrst), .irq_o(irq));
	rcmb_src_model i_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
		.src_o(src));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ----------------------------------------------------------------
	// bus and source helpers
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		req <= '{read: !w, write: w, address: a, byteenable: 4'hf, writedata: d};
		do @(posedge clk_i); while (wr !== 1'b0);
		q = rd;
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [31:0] e,
		input string n);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(n, e, q)
	endtask
	task automatic fire_src(input rcmb_src_type s);
		fire <= s;
		@(posedge clk_i);
		fire <= '0;
		repeat (2) @(posedge clk_i);
		`CHK("rst on", 1'b1, mrst)
		repeat (4) @(posedge clk_i);
		`CHK("rst off", 1'b0, mrst)
	endtask
	task automatic t_por();
		chk_rd(RCMB_OFS_CAUSE, 32'h003, "cause");
		chk_rd(RCMB_OFS_STAT, 32'h003, "stat");
		chk_rd(RCMB_OFS_MASK, 32'h000, "mask");
		chk_rd(4'h2, 32'h000, "unmapped");
		$display("t_por done");
	endtask
	task automatic t_src();
		logic [31:0] q;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, RCMB_OFS_CAUSE, 32'h0, q);
			fire_src(rcmb_src_type'(8'h1 << i));
			chk_rd(RCMB_OFS_CAUSE, 32'h2 << i, "cause bit");
		end
		bus(1'b1, RCMB_OFS_CAUSE, 32'h1ff, q);
		`CHK("no rst", 1'b0, mrst)
		chk_rd(RCMB_OFS_CAUSE, 32'h1ff, "cause set");
		bus(1'b1, RCMB_OFS_CAUSE, 32'h0, q);
		chk_rd(RCMB_OFS_CAUSE, 32'h0, "cause clr");
		$display("t_src done");
	endtask
	task automatic t_irq();
		logic [31:0] q;
		chk_rd(RCMB_OFS_STAT, 32'h1fe, "stat all");
		bus(1'b1, RCMB_OFS_MASK, 32'h008, q);
		fire_src(rcmb_src_type'(8'h04));
		chk_rd(RCMB_OFS_MASK, 32'h000, "mask in rst");
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, RCMB_OFS_MASK, (i == 1) ? 32'h0 : 32'h008, q);
			@(posedge clk_i);
			`CHK("irq", (i != 1), irq)
		end
		chk_rd(RCMB_OFS_STAT, 32'h008, "stat wdt");
		@(posedge clk_i);
		`CHK("irq clr", 1'b0, irq)
		$display("t_irq done");
	endtask
	task automatic t_keep();
		logic [31:0] q;
		bus(1'b1, RCMB_OFS_SCRATCH, 32'ha5a5_0f0f, q);
		fire_src(rcmb_src_type'(8'h08));
		chk_rd(RCMB_OFS_SCRATCH, 32'ha5a5_0f0f, "scratch");
		chk_rd(RCMB_OFS_CAUSE, 32'h018, "cause kept");
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk_rd(RCMB_OFS_CAUSE, 32'h003, "por cause");
		$display("t_keep done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// limit is many times the fewer than two hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		rst_n_i = 1'b0;
		fire = '0;
		req = '0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_por();
		t_src();
		t_irq();
		t_keep();
		end_sim();
	end
endmodule // reset_source_combiner_tb
